/* hw/cbf_params.svh */
// Register map, field positions and reset values of the buffer and filter register block.
// Assumes byte-wide registers behind an 8-bit address on a plain strobe port.
`ifndef CBF_PARAMS_SVH
`define CBF_PARAMS_SVH

// ----------------------------------------------------------------------------
// Address map
// ----------------------------------------------------------------------------
`define CBF_OFS_SIDH     4'h0
`define CBF_OFS_SIDL     4'h1
`define CBF_OFS_EIDH     4'h2
`define CBF_OFS_EIDL     4'h3
`define CBF_OFS_DLC      4'h4
`define CBF_OFS_DATA0    4'h5
`define CBF_OFS_DATA7    4'hC
`define CBF_OFS_CTRL     4'hD
`define CBF_BSEL_ADDR    8'h60
`define CBF_FILT_TAG     2'h2

// ----------------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------------
`define CBF_SIDL_WMASK   8'hEB
`define CBF_DLC_WMASK    8'h4F
`define CBF_BSEL_WMASK   8'hFC
`define CBF_RTR_BIT      6
`define CBF_FULL_BIT     7
`define CBF_EXT_BIT      3
`define CBF_DLC_MAX      4'h8
`define CBF_LEGACY_FILTS 6
`define CBF_BYTE_RESET   8'h00

`endif

/* hw/cbf_pkg.sv */
// Types shared by the buffer and filter register block and its surroundings.
// Assumes identifiers are carried left aligned in 29 bits.
package cbf_pkg;

   // -------------------------------------------------------------------------
   // Operating modes and frame carrier
   // -------------------------------------------------------------------------
   typedef enum logic [1:0] {
      CBF_MODE_LEGACY,
      CBF_MODE_ENH1,
      CBF_MODE_ENH2
   } cbf_mode_t;

   typedef struct packed {
      logic [28:0] id;
      logic        ext;
      logic        rtr;
      logic [3:0]  dlc;
      logic [63:0] data;
   } cbf_frame_t;

endpackage

/* hw/cbf_regs.sv */
// Six programmable transmit/receive message buffers and sixteen acceptance filters.
// Assumes the protocol engine loads received frames and fetches transmit frames
// through the frame ports, and that software uses the byte-wide register port.
//
// Functional notes
// - Direction bit 1 makes a buffer transmit, 0 receive; reset 0, low bits read 0.
// - Length code 0 to 8 gives byte count; codes 9 to 15 are reserved.
// - Transmit buffer sends remote request bit equal to its remote request flag.
// - Receive buffer remote request flag records whether stored frame was remote.
// - Receive length bits 5 and 4 are reserved protocol bits reading zero.
// - Transmit length bits 7, 5, 4 read zero; only flag and code writable.
// - Eight data bytes per buffer; read-only in receive, writable in transmit.
// - Extended identifier middle and low bytes; read-only receive, writable transmit.
// - All buffers, and filters 6 to 15, only usable in enhanced modes.
// - Filter extended select picks extended-only or standard-only frames.
// - Filter high and top low bits compare extended 28:18 or standard 10:0.
// - Filter holds extended bits 17:0; low byte bits 4 and 2 read zero.
// - Buffer registers other than the full flag are read-only while transmit is requested or in progress.
// - Full receive buffer takes no new frame until software clears the flag.
`timescale 1ns/100ps
`include "cbf_params.svh"

module cbf_regs #(
   parameter int NUM_BUF  = 6,
   parameter int NUM_FILT = 16
) (
   input  wire logic                  ref_clk_i,
   input  wire logic                  reset_i,
   input  wire logic [7:0]            reg_addr_i,
   input  wire logic [7:0]            reg_wdata_i,
   input  wire logic                  reg_wr_i,
   input  wire logic                  reg_rd_i,
   output logic [7:0]                 reg_rdata_o,
   input  cbf_pkg::cbf_mode_t         op_mode_i,
   input  wire logic [NUM_BUF-1:0]    transmit_request_flag_i,
   input  wire logic [NUM_BUF-1:0]    tx_busy_i,
   input  wire logic [2:0]            tx_sel_i,
   output cbf_pkg::cbf_frame_t        tx_frame_o,
   output logic [3:0]                 tx_bytes_o,
   input  wire logic                  rx_store_i,
   input  wire logic [2:0]            rx_buf_i,
   input  cbf_pkg::cbf_frame_t        rx_frame_i,
   output logic                       rx_stored_o,
   output logic                       rx_dropped_o,
   output logic [NUM_BUF-1:0]         buffer_tx_select_bits_o,
   output logic [NUM_BUF-1:0]         receive_full_flag_o,
   input  wire logic [NUM_FILT-1:0]   filt_enable_i,
   input  wire logic [28:0]           mask_id_i,
   input  wire logic                  mask_ext_check_i,
   output logic [NUM_FILT-1:0]        filt_hit_o
);
   import cbf_pkg::*;

   // -------------------------------------------------------------------------
   // Elaboration checks
   // -------------------------------------------------------------------------
   if (NUM_BUF < 1 || NUM_BUF > 6) begin : g_chk_buf
      $error("NUM_BUF must lie between 1 and 6");
   end
   if (NUM_FILT <= `CBF_LEGACY_FILTS || NUM_FILT > 16) begin : g_chk_filt
      $error("NUM_FILT must lie between 7 and 16");
   end

   // -------------------------------------------------------------------------
   // Storage
   // -------------------------------------------------------------------------
   logic [7:0]         sidh_reg [NUM_BUF];
   logic [7:0]         sidl_reg [NUM_BUF];
   logic [7:0]         eidh_reg [NUM_BUF];
   logic [7:0]         eidl_reg [NUM_BUF];
   logic               rtr_reg  [NUM_BUF];
   logic [3:0]         dlc_reg  [NUM_BUF];
   logic [7:0]         data_reg [NUM_BUF][8];
   logic [NUM_BUF-1:0] full_reg;
   logic [NUM_BUF-1:0] bsel_reg;
   logic [7:0]         fsidh_reg [NUM_FILT];
   logic [7:0]         fsidl_reg [NUM_FILT];
   logic [7:0]         feidh_reg [NUM_FILT];
   logic [7:0]         feidl_reg [NUM_FILT];
   logic [7:0]         rdata_reg;
   logic [7:0]         rdata_next;
   logic               enhanced;
   logic               buf_hit;
   logic               filt_hit;
   logic [2:0]         buf_idx;
   logic [3:0]         buf_ofs;
   logic [3:0]         filt_idx;
   logic [1:0]         filt_ofs;
   logic               rx_accept;

   // -------------------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------------------
   function automatic logic [28:0] pack_id(input logic [7:0] hi, input logic [7:0] lo,
                                           input logic [7:0] eh, input logic [7:0] el);
      return {hi, lo[7:5], lo[1:0], eh, el};
   endfunction

   function automatic logic [3:0] dlc_bytes(input logic [3:0] code);
      return (code > `CBF_DLC_MAX) ? `CBF_DLC_MAX : code;
   endfunction

   // A buffer accepts software writes to its contents only as an idle transmit buffer.
   function automatic logic buf_writable(input int b);
      return bsel_reg[b] && !transmit_request_flag_i[b] && !tx_busy_i[b];
   endfunction

   function automatic logic filt_usable(input int f);
      return (f < `CBF_LEGACY_FILTS) || enhanced;
   endfunction

   // -------------------------------------------------------------------------
   // Address decode
   // -------------------------------------------------------------------------
   assign enhanced = (op_mode_i != CBF_MODE_LEGACY);
   assign buf_idx  = reg_addr_i[6:4];
   assign buf_ofs  = reg_addr_i[3:0];
   assign filt_idx = reg_addr_i[5:2];
   assign filt_ofs = reg_addr_i[1:0];

   always_comb begin
      buf_hit  = 1'b0;
      filt_hit = 1'b0;
      if (!reg_addr_i[7] && (32'(buf_idx) < NUM_BUF) && (buf_ofs <= `CBF_OFS_CTRL)) begin
         buf_hit = enhanced;
      end else if (reg_addr_i[7:6] == `CBF_FILT_TAG && 32'(filt_idx) < NUM_FILT) begin
         filt_hit = filt_usable(32'(filt_idx));
      end
   end

   // A frame lands only in an enhanced-mode receive buffer that is open.
   assign rx_accept = rx_store_i && enhanced && (32'(rx_buf_i) < NUM_BUF)
                      && !bsel_reg[rx_buf_i] && !full_reg[rx_buf_i];

   // -------------------------------------------------------------------------
   // Direction select
   // -------------------------------------------------------------------------
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         bsel_reg <= '0;
      end else if (reg_wr_i && enhanced && reg_addr_i == `CBF_BSEL_ADDR) begin
         bsel_reg <= reg_wdata_i[NUM_BUF+1:2];
      end
   end

   // -------------------------------------------------------------------------
   // Buffer contents
   // -------------------------------------------------------------------------
   always_ff @(posedge ref_clk_i) begin
      for (int b = 0; b < NUM_BUF; b++) begin
         if (reset_i) begin
            sidh_reg[b] <= `CBF_BYTE_RESET;
            sidl_reg[b] <= `CBF_BYTE_RESET;
            eidh_reg[b] <= `CBF_BYTE_RESET;
            eidl_reg[b] <= `CBF_BYTE_RESET;
            rtr_reg[b]  <= 1'b0;
            dlc_reg[b]  <= 4'h0;
            for (int m = 0; m < 8; m++) begin
               data_reg[b][m] <= `CBF_BYTE_RESET;
            end
         end else if (rx_accept && rx_buf_i == 3'(b)) begin
            sidh_reg[b] <= rx_frame_i.id[28:21];
            sidl_reg[b] <= {rx_frame_i.id[20:18], 1'b0, rx_frame_i.ext, 1'b0,
                            rx_frame_i.id[17:16]};
            eidh_reg[b] <= rx_frame_i.id[15:8];
            eidl_reg[b] <= rx_frame_i.id[7:0];
            rtr_reg[b]  <= rx_frame_i.rtr;
            dlc_reg[b]  <= rx_frame_i.dlc;
            for (int m = 0; m < 8; m++) begin
               data_reg[b][m] <= rx_frame_i.data[8*m +: 8];
            end
         end else if (reg_wr_i && buf_hit && buf_idx == 3'(b) && buf_writable(b)) begin
            if (buf_ofs == `CBF_OFS_SIDH) begin
               sidh_reg[b] <= reg_wdata_i;
            end else if (buf_ofs == `CBF_OFS_SIDL) begin
               sidl_reg[b] <= reg_wdata_i & `CBF_SIDL_WMASK;
            end else if (buf_ofs == `CBF_OFS_EIDH) begin
               eidh_reg[b] <= reg_wdata_i;
            end else if (buf_ofs == `CBF_OFS_EIDL) begin
               eidl_reg[b] <= reg_wdata_i;
            end else if (buf_ofs == `CBF_OFS_DLC) begin
               rtr_reg[b] <= reg_wdata_i[`CBF_RTR_BIT];
               dlc_reg[b] <= reg_wdata_i[3:0];
            end else if (buf_ofs >= `CBF_OFS_DATA0 && buf_ofs <= `CBF_OFS_DATA7) begin
               data_reg[b][3'(buf_ofs - `CBF_OFS_DATA0)] <= reg_wdata_i;
            end
         end
      end
   end

   // -------------------------------------------------------------------------
   // Receive full flags
   // -------------------------------------------------------------------------
   // The flag is only set when clear, but a store and a software clear of the
   // same buffer can still meet in one cycle; the set is placed first and wins.
   always_ff @(posedge ref_clk_i) begin
      for (int b = 0; b < NUM_BUF; b++) begin
         if (reset_i) begin
            full_reg[b] <= 1'b0;
         end else if (rx_accept && rx_buf_i == 3'(b)) begin
            full_reg[b] <= 1'b1;
         end else if (reg_wr_i && buf_hit && buf_idx == 3'(b) && buf_ofs == `CBF_OFS_CTRL
                      && !reg_wdata_i[`CBF_FULL_BIT]) begin
            full_reg[b] <= 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         rx_stored_o  <= 1'b0;
         rx_dropped_o <= 1'b0;
      end else begin
         rx_stored_o  <= rx_accept;
         rx_dropped_o <= rx_store_i && !rx_accept;
      end
   end

   // -------------------------------------------------------------------------
   // Acceptance filters
   // -------------------------------------------------------------------------
   always_ff @(posedge ref_clk_i) begin
      for (int f = 0; f < NUM_FILT; f++) begin
         if (reset_i) begin
            fsidh_reg[f] <= `CBF_BYTE_RESET;
            fsidl_reg[f] <= `CBF_BYTE_RESET;
            feidh_reg[f] <= `CBF_BYTE_RESET;
            feidl_reg[f] <= `CBF_BYTE_RESET;
         end else if (reg_wr_i && filt_hit && filt_idx == 4'(f)) begin
            if (filt_ofs == 2'h0) begin
               fsidh_reg[f] <= reg_wdata_i;
            end else if (filt_ofs == 2'h1) begin
               fsidl_reg[f] <= reg_wdata_i & `CBF_SIDL_WMASK;
            end else if (filt_ofs == 2'h2) begin
               feidh_reg[f] <= reg_wdata_i;
            end else begin
               feidl_reg[f] <= reg_wdata_i;
            end
         end
      end
   end

   // Standard filters compare only the eleven top identifier bits; the type
   // check is always enforced in legacy mode, whatever the mask says.
   always_ff @(posedge ref_clk_i) begin
      for (int f = 0; f < NUM_FILT; f++) begin
         if (reset_i) begin
            filt_hit_o[f] <= 1'b0;
         end else begin
            filt_hit_o[f] <= filt_enable_i[f] && filt_usable(f)
               && ((pack_id(fsidh_reg[f], fsidl_reg[f], feidh_reg[f], feidl_reg[f])
                    ^ rx_frame_i.id)
                   & (fsidl_reg[f][`CBF_EXT_BIT] ? mask_id_i
                      : {mask_id_i[28:18], 18'h0})) == 29'h0
               && ((enhanced && !mask_ext_check_i)
                   || fsidl_reg[f][`CBF_EXT_BIT] == rx_frame_i.ext);
         end
      end
   end

   // -------------------------------------------------------------------------
   // Transmit frame view
   // -------------------------------------------------------------------------
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         tx_frame_o <= '0;
         tx_bytes_o <= 4'h0;
      end else if (32'(tx_sel_i) < NUM_BUF) begin
         tx_frame_o.id  <= pack_id(sidh_reg[tx_sel_i], sidl_reg[tx_sel_i],
                                   eidh_reg[tx_sel_i], eidl_reg[tx_sel_i]);
         tx_frame_o.ext <= sidl_reg[tx_sel_i][`CBF_EXT_BIT];
         tx_frame_o.rtr <= rtr_reg[tx_sel_i];
         tx_frame_o.dlc <= dlc_reg[tx_sel_i];
         for (int m = 0; m < 8; m++) begin
            tx_frame_o.data[8*m +: 8] <= data_reg[tx_sel_i][m];
         end
         tx_bytes_o <= dlc_bytes(dlc_reg[tx_sel_i]);
      end
   end

   // -------------------------------------------------------------------------
   // Register read path
   // -------------------------------------------------------------------------
   always_comb begin
      rdata_next = 8'h00;
      if (reg_rd_i) begin
         if (buf_hit) begin
            if (buf_ofs == `CBF_OFS_SIDH) begin
               rdata_next = sidh_reg[buf_idx];
            end else if (buf_ofs == `CBF_OFS_SIDL) begin
               rdata_next = sidl_reg[buf_idx];
            end else if (buf_ofs == `CBF_OFS_EIDH) begin
               rdata_next = eidh_reg[buf_idx];
            end else if (buf_ofs == `CBF_OFS_EIDL) begin
               rdata_next = eidl_reg[buf_idx];
            end else if (buf_ofs == `CBF_OFS_DLC) begin
               rdata_next = {1'b0, rtr_reg[buf_idx], 2'b00, dlc_reg[buf_idx]};
            end else if (buf_ofs == `CBF_OFS_CTRL) begin
               rdata_next = {full_reg[buf_idx], 7'h00};
            end else begin
               rdata_next = data_reg[buf_idx][3'(buf_ofs - `CBF_OFS_DATA0)];
            end
         end else if (filt_hit) begin
            if (filt_ofs == 2'h0) begin
               rdata_next = fsidh_reg[filt_idx];
            end else if (filt_ofs == 2'h1) begin
               rdata_next = fsidl_reg[filt_idx];
            end else if (filt_ofs == 2'h2) begin
               rdata_next = feidh_reg[filt_idx];
            end else begin
               rdata_next = feidl_reg[filt_idx];
            end
         end else if (enhanced && reg_addr_i == `CBF_BSEL_ADDR) begin
            rdata_next = 8'({bsel_reg, 2'b00}) & `CBF_BSEL_WMASK;
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         rdata_reg <= 8'h00;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   assign reg_rdata_o             = rdata_reg;
   assign buffer_tx_select_bits_o = bsel_reg;
   assign receive_full_flag_o     = full_reg;

endmodule

/* bench/cbf_regs_monitor.sv */
// Port checks for the buffer and filter register block.
// Assumes it is bound to cbf_regs with the parameters handed on.
`timescale 1ns/100ps
module cbf_regs_monitor #(
   parameter int NUM_BUF  = 6,
   parameter int NUM_FILT = 16
) (
   input  wire logic                ref_clk_i,
   input  wire logic                reset_i,
   input  wire logic [7:0]          reg_addr_i,
   input  wire logic                reg_wr_i,
   input  wire logic                reg_rd_i,
   input  wire logic [7:0]          reg_rdata_o,
   input  cbf_pkg::cbf_mode_t       op_mode_i,
   input  cbf_pkg::cbf_frame_t      tx_frame_o,
   input  wire logic [3:0]          tx_bytes_o,
   input  wire logic                rx_store_i,
   input  wire logic [2:0]          rx_buf_i,
   input  wire logic                rx_stored_o,
   input  wire logic                rx_dropped_o,
   input  wire logic [NUM_BUF-1:0]  buffer_tx_select_bits_o,
   input  wire logic [NUM_BUF-1:0]  receive_full_flag_o,
   input  wire logic [NUM_FILT-1:0] filt_enable_i,
   input  wire logic [NUM_FILT-1:0] filt_hit_o
);
   import cbf_pkg::*;
   // ----------------
   // Checks
   // ----------------
   logic sel_wr;
   always_ff @(posedge ref_clk_i) begin
      sel_wr <= reg_wr_i && reg_addr_i == 8'h60 && op_mode_i != CBF_MODE_LEGACY;
   end
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (reset_i);
   sequence s_store;
      rx_store_i ##1 rx_stored_o;
   endsequence
   sequence s_refused;
      rx_store_i && rx_buf_i < NUM_BUF
         && (receive_full_flag_o[rx_buf_i] || buffer_tx_select_bits_o[rx_buf_i]);
   endsequence
   bsel_low_a: assert property (
      reg_rd_i && reg_addr_i == 8'h60 |=> reg_rdata_o[1:0] == 2'b00)
      else $error("direction select low bits not zero");
   bsel_write_a: assert property (
      !$past(reset_i) && $changed(buffer_tx_select_bits_o) |-> sel_wr)
      else $error("direction bits changed without a write");
   len_zero_a: assert property (
      reg_rd_i && reg_addr_i < 8'h60 && reg_addr_i[3:0] == 4'h4
      |=> (reg_rdata_o & 8'hB0) == 8'h00) else $error("length spare bits not zero");
   sidl_zero_a: assert property (
      reg_rd_i && reg_addr_i[7] && reg_addr_i[1:0] == 2'b01
      |=> (reg_rdata_o & 8'h14) == 8'h00) else $error("filter low byte spare bits set");
   tx_bytes_a: assert property (
      tx_bytes_o == ((tx_frame_o.dlc > 4'h8) ? 4'h8 : tx_frame_o.dlc))
      else $error("byte count does not follow length code");
   refused_drop_a: assert property (s_refused |=> rx_dropped_o && !rx_stored_o)
      else $error("frame loaded into full or transmit buffer");
   legacy_drop_a: assert property (
      rx_store_i && op_mode_i == CBF_MODE_LEGACY |=> rx_dropped_o)
      else $error("frame stored in legacy mode");
   store_full_a: assert property (s_store |-> receive_full_flag_o[$past(rx_buf_i)])
      else $error("full flag not set by a stored frame");
   filt_off_a: assert property (1'b1 |=> (filt_hit_o & ~$past(filt_enable_i)) == '0)
      else $error("disabled filter reported a hit");
   legacy_filt_a: assert property (
      op_mode_i == CBF_MODE_LEGACY |=> filt_hit_o[NUM_FILT-1:6] == '0)
      else $error("upper filter hit in legacy mode");
endmodule

/* bench/cbf_node_model.sv */
// Far-side node model: hands received frames to the buffer block.
// Assumes the bench asks for one frame at a time on req_i.
`timescale 1ns/100ps
module cbf_node_model (
   input  wire logic           ref_clk_i,
   input  wire logic           req_i,
   input  wire logic           keep_i,
   input  wire logic [2:0]     buf_i,
   input  cbf_pkg::cbf_frame_t frame_i,
   output logic                rx_store_o,
   output logic [2:0]          rx_buf_o,
   output cbf_pkg::cbf_frame_t rx_frame_o
);
   import cbf_pkg::*;
   initial begin
      rx_store_o = 1'b0;
      rx_buf_o   = 3'h0;
      rx_frame_o = '0;
   end
   // Between frames the frame lines carry a pattern that changes every cycle.
   always @(posedge ref_clk_i) begin
      rx_store_o <= req_i & keep_i;
      rx_buf_o   <= buf_i;
      rx_frame_o <= req_i ? frame_i : ~rx_frame_o;
   end
endmodule

/* bench/can_buffer_filter_regs_tb_top.sv */
// Self-checking bench for the buffer and filter register block.
// Assumes the package, design, node model and monitor are compiled first.
`timescale 1ns/100ps
module can_buffer_filter_regs_tb_top;
   import cbf_pkg::*;
   logic        clk   = 1'b0;
   logic        rst   = 1'b1;
   logic [7:0]  addr  = 8'h00;
   logic [7:0]  wdata = 8'h00;
   logic        wr    = 1'b0;
   logic        rd    = 1'b0;
   cbf_mode_t   mode  = CBF_MODE_ENH1;
   logic [5:0]  transmit_request_flag = 6'h00;
   logic [5:0]  busy  = 6'h00;
   logic [15:0] fen   = 16'h004C;
   logic        mchk  = 1'b1;
   logic [28:0] mask  = 29'h1FFF_FFFF;
   logic        nreq  = 1'b0;
   logic        nkeep = 1'b0;
   logic [2:0]  nbuf  = 3'h0;
   cbf_frame_t  nfr   = '0;
   logic        rd_d  = 1'b0;
   logic [28:0] eid   = 29'h1234_5678;
   logic [28:0] sid   = {11'h123, 18'h0};
   logic [31:0] rnd   = 32'h062E2E3C;
   logic [7:0]  rdata, xl;
   logic        st, dr, rx_st;
   logic [2:0]  rx_b;
   logic [3:0]  tx_n;
   logic [5:0]  bsel, full;
   logic [15:0] hit;
   logic [63:0] dat;
   cbf_frame_t  rx_f, tx_f, fr;
   logic [7:0]  rq[$];
   logic        sq[$];
   int          bad_count    = 0;
   int          total_checks = 0;
   assign xl = {eid[20:18], 1'b0, 1'b1, 1'b0, eid[17:16]};
   always #10 clk = ~clk;
   cbf_regs i_dut (
      .ref_clk_i(clk), .reset_i(rst), .reg_addr_i(addr), .reg_wdata_i(wdata),
      .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .op_mode_i(mode),
      .transmit_request_flag_i(transmit_request_flag), .tx_busy_i(busy), .tx_sel_i(3'h0),
      .tx_frame_o(tx_f), .tx_bytes_o(tx_n), .rx_store_i(rx_st), .rx_buf_i(rx_b),
      .rx_frame_i(rx_f), .rx_stored_o(st), .rx_dropped_o(dr),
      .buffer_tx_select_bits_o(bsel), .receive_full_flag_o(full), .filt_enable_i(fen),
      .mask_id_i(mask), .mask_ext_check_i(mchk), .filt_hit_o(hit));
   cbf_node_model i_node (
      .ref_clk_i(clk), .req_i(nreq), .keep_i(nkeep), .buf_i(nbuf), .frame_i(nfr),
      .rx_store_o(rx_st), .rx_buf_o(rx_b), .rx_frame_o(rx_f));
   // ----------------
   // Tasks
   // ----------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
      total_checks++;
      if (g !== e) begin
         bad_count++;
         $display("unexpected %s: expected %h, seen %h", n, e, g);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      {addr, wdata, wr, rd} <= {a, d, 2'b10};
   endtask
   task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      {addr, wr, rd} <= {a, 2'b01};
      rq.push_back(e);
   endtask
   task automatic idle(input int n);
      repeat (n) begin
         @(posedge clk);
         {wr, rd, nreq} <= 3'b000;
      end
      #1;
   endtask
   task automatic send(input logic [2:0] b, input cbf_frame_t f, input logic e);
      @(posedge clk);
      {nreq, nkeep, nbuf, nfr} <= {2'b11, b, f};
      sq.push_back(e);
      idle(3);
   endtask
   task automatic probe(input cbf_frame_t f, input logic [15:0] e);
      @(posedge clk);
      {nreq, nkeep, nfr} <= {2'b10, f};
      @(posedge clk);
      nreq <= 1'b0;
      @(posedge clk);
      #1;
      chk("filter hits", e, hit);
   endtask
   task automatic tally_and_finish();
      $display("checks %0d, mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   always @(posedge clk) begin
      rd_d <= rd;
      if (rd_d) chk("read data", rq.pop_front(), rdata);
      if (st | dr) chk("frame taken", sq.pop_front(), st);
   end
   initial begin
      repeat (3000) @(posedge clk);
      bad_count++;
      tally_and_finish();
   end
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      idle(1);
      rd_reg(8'h60, 8'h00);
      rd_reg(8'h14, 8'h00);
      wr_reg(8'h60, 8'hFF);
      rd_reg(8'h60, 8'hFC);
      rd_reg(8'h7F, 8'h00);
      wr_reg(8'h04, 8'hFF);
      rd_reg(8'h04, 8'h4F);
      for (int m = 0; m < 8; m++) begin
         rnd = lfsr(rnd);
         dat[m*8 +: 8] = rnd[7:0];
         wr_reg(8'h05 + m[7:0], rnd[7:0]);
      end
      wr_reg(8'h02, 8'hA5);
      wr_reg(8'h03, 8'h3C);
      rd_reg(8'h02, 8'hA5);
      rd_reg(8'h07, dat[23:16]);
      idle(2);
      chk("direction", 6'h3F, bsel);
      chk("tx rtr", 1'b1, tx_f.rtr);
      chk("tx data", dat, tx_f.data);
      chk("tx id", 16'hA53C, tx_f.id[15:0]);
      for (int c = 0; c < 16; c++) begin
         wr_reg(8'h04, c[7:0]);
         idle(2);
         chk("tx bytes", (c > 8) ? 8 : c, tx_n);
      end
      chk("tx rtr", 1'b0, tx_f.rtr);
      for (int k = 0; k < 2; k++) begin
         @(posedge clk) {transmit_request_flag, busy} <= k ? 12'h040 : 12'h001;
         wr_reg(8'h05, ~dat[7:0]);
         rd_reg(8'h05, dat[7:0]);
         idle(1);
      end
      @(posedge clk) begin
         {transmit_request_flag, busy} <= 12'h000;
         mode          <= CBF_MODE_ENH2;
      end
      wr_reg(8'h60, 8'h00);
      idle(1);
      rnd = lfsr(rnd);
      fr = '{id: eid, ext: 1'b1, rtr: 1'b1, dlc: 4'h3, data: {rnd, ~rnd}};
      send(3'h1, fr, 1'b1);
      rd_reg(8'h11, xl);
      rd_reg(8'h13, eid[7:0]);
      rd_reg(8'h14, 8'h43);
      wr_reg(8'h1C, 8'h00);
      wr_reg(8'h12, 8'h00);
      rd_reg(8'h1C, fr.data[63:56]);
      rd_reg(8'h12, eid[15:8]);
      rd_reg(8'h1D, 8'h80);
      idle(1);
      chk("full", 6'h02, full);
      fr.rtr = 1'b0;
      send(3'h1, fr, 1'b0);
      wr_reg(8'h1D, 8'h00);
      idle(1);
      send(3'h1, fr, 1'b1);
      rd_reg(8'h14, 8'h03);
      wr_reg(8'h60, 8'h04);
      idle(1);
      send(3'h0, fr, 1'b0);
      @(posedge clk) mode <= CBF_MODE_LEGACY;
      send(3'h2, fr, 1'b0);
      wr_reg(8'h60, 8'hFF);
      wr_reg(8'h98, 8'h5A);
      rd_reg(8'h98, 8'h00);
      wr_reg(8'h89, 8'hFF);
      rd_reg(8'h89, 8'hEB);
      wr_reg(8'h88, eid[28:21]);
      wr_reg(8'h89, xl);
      wr_reg(8'h8A, eid[15:8]);
      wr_reg(8'h8B, eid[7:0]);
      wr_reg(8'h8C, sid[28:21]);
      wr_reg(8'h8D, {sid[20:18], 5'h00});
      idle(1);
      chk("direction", 6'h01, bsel);
      probe('{id: eid, ext: 1'b1, default: '0}, 16'h0004);
      probe('{id: sid | 29'h3FFFF, ext: 1'b0, default: '0}, 16'h0008);
      probe('{id: eid, ext: 1'b0, default: '0}, 16'h0000);
      probe('{default: '0}, 16'h0000);
      @(posedge clk) begin
         mode <= CBF_MODE_ENH1;
         mchk <= 1'b0;
      end
      probe('{id: eid, ext: 1'b0, default: '0}, 16'h0004);
      probe('{default: '0}, 16'h0040);
      @(posedge clk) fen <= 16'h0004;
      probe('{id: sid, ext: 1'b0, default: '0}, 16'h0000);
      @(posedge clk) mask <= 29'h1FFF_FF00;
      probe('{id: eid ^ 29'h55, ext: 1'b1, default: '0}, 16'h0004);
      wr_reg(8'h98, 8'h5A);
      rd_reg(8'h98, 8'h5A);
      idle(3);
      tally_and_finish();
   end
endmodule

bind cbf_regs cbf_regs_monitor #(.NUM_BUF(NUM_BUF), .NUM_FILT(NUM_FILT)) i_mon (
   .ref_clk_i(ref_clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
   .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .op_mode_i(op_mode_i),
   .tx_frame_o(tx_frame_o), .tx_bytes_o(tx_bytes_o), .rx_store_i(rx_store_i),
   .rx_buf_i(rx_buf_i), .rx_stored_o(rx_stored_o), .rx_dropped_o(rx_dropped_o),
   .buffer_tx_select_bits_o(buffer_tx_select_bits_o),
   .receive_full_flag_o(receive_full_flag_o), .filt_enable_i(filt_enable_i),
   .filt_hit_o(filt_hit_o));
